// ==== shared/pdc_pkg.sv ====
// Constants, register map and field layouts of the PWM post-processing core.
// Assumes a classic Wishbone slave with byte addresses and 32-bit data.
package pdc_pkg;

    localparam logic [7:0] DT_CFG_OFS = 8'h58;
    localparam logic [7:0] FED_OFS = 8'h5c;
    localparam logic [7:0] RED_OFS = 8'h60;
    localparam logic [7:0] CAR_OFS = 8'h64;
    localparam logic [7:0] TRIP0_OFS = 8'h68;
    localparam logic [7:0] TRIP1_OFS = 8'h6c;
    localparam logic [7:0] TRIPS_OFS = 8'h70;
    localparam logic [7:0] STC_OFS = 8'h74;
    localparam logic [7:0] STA_OFS = 8'h78;
    localparam logic [7:0] STB_OFS = 8'h7c;
    localparam logic [7:0] G1C_OFS = 8'h80;

    localparam int NSH = 5;
    localparam logic [NSH-1:0][7:0] SH_OFS = {G1C_OFS, STB_OFS, STA_OFS, RED_OFS, FED_OFS};
    localparam logic [NSH-1:0][31:0] SH_MASK = {32'h0000_03ff, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    localparam int UPD_TEZ = 0;
    localparam int UPD_TEP = 1;
    localparam int UPD_SYNC = 2;
    localparam int UPD_OFF = 3;
    localparam int ST_CBC_BIT = 0;
    localparam int ST_OST_BIT = 1;
    localparam logic [2:0] TSEL_SYNC = 3'h3;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOG = 2'h3
    } pdc_act_t;

    typedef struct packed {
        logic [13:0] pad;
        logic clk_sel;
        logic b_bypass;
        logic a_bypass;
        logic fed_inv;
        logic red_inv;
        logic fed_insel;
        logic red_insel;
        logic b_swap;
        logic a_swap;
        logic dual_edge_b_path_mode;
        logic [3:0] red_up;
        logic [3:0] fed_up;
    } pdc_dt_cfg_t;

    typedef struct packed {
        logic [17:0] pad;
        logic in_inv;
        logic out_inv;
        logic [3:0] first_pulse_width;
        logic [2:0] duty;
        logic [3:0] prescale;
        logic en;
    } pdc_car_cfg_t;

    typedef struct packed {
        logic [7:0] pad;
        logic [3:0] ost_en;
        logic [3:0] cbc_en;
        pdc_act_t b_ost_u;
        pdc_act_t b_ost_d;
        pdc_act_t b_cbc_u;
        pdc_act_t b_cbc_d;
        pdc_act_t a_ost_u;
        pdc_act_t a_ost_d;
        pdc_act_t a_cbc_u;
        pdc_act_t a_cbc_d;
    } pdc_trip0_t;

    typedef struct packed {
        logic [26:0] pad;
        logic force_ost;
        logic force_cbc;
        logic [1:0] refresh_sel;
        logic clr_ost;
    } pdc_trip1_t;

    typedef struct packed {
        logic [21:0] pad;
        logic [2:0] t1_sel;
        logic [2:0] t0_sel;
        logic [3:0] cfg_up;
    } pdc_g1c_t;

endpackage

// ==== core/pdc_core.sv ====
// Dead-time, carrier and trip stage of PWM operator 0 plus generator 1 setup.
// Assumes timer count, period, direction and tick arrive synchronous to SYS_CLK.
//
// The Wishbone interface to the registers was decided locally.
module pdc_core
    import pdc_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Timer and generator side.
    input wire logic [15:0] TIMER_CNT,
    input wire logic [15:0] TIMER_PERIOD,
    input wire logic TIMER_DIR_DOWN,
    input wire logic TIMER_PRESCALED_CLOCK,
    input wire logic SYNC_IN,
    input wire logic PWM_A_IN,
    input wire logic PWM_B_IN,
    input wire logic [2:0] FAULT_IN,
    // Power stage and generator 1 side.
    output logic OPERATOR0_OUTPUT_A,
    output logic OPERATOR0_OUTPUT_B,
    output logic GENERATOR_TRIGGER_ZERO,
    output logic GENERATOR_TRIGGER_ONE,
    output logic [15:0] GEN1_STAMP_A,
    output logic [15:0] GEN1_STAMP_B,
    output logic [9:0] GEN1_CFG_ACTIVE,
    output logic ONESHOT_ACTIVE_FLAG,
    output logic PER_CYCLE_ACTIVE_FLAG
);

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        for (int k = 0; k < 4; k++) begin
            wmerge[8*k+:8] = s[k] ? d[8*k+:8] : o[8*k+:8];
        end
    endfunction

    function automatic logic upd_now(input logic [3:0] m, input logic z, input logic p,
                                     input logic y);
        upd_now = (m == 4'h0) |
            (!m[UPD_OFF] & ((m[UPD_TEZ] & z) | (m[UPD_TEP] & p) | (m[UPD_SYNC] & y)));
    endfunction

    function automatic logic act_apply(input pdc_act_t a, input logic v);
        case (a)
            ACT_LOW: act_apply = 1'b0;
            ACT_HIGH: act_apply = 1'b1;
            ACT_TOG: act_apply = ~v;
            default: act_apply = v;
        endcase
    endfunction

    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] dt_cfg_q;
    logic [31:0] car_q;
    logic [31:0] trip0_q;
    logic [31:0] trip1_q;
    logic [7:0] stc_up_q;
    logic [31:0] sh_q [NSH];
    logic [31:0] act_q [NSH];
    logic [NSH-1:0] pend_q;
    logic [NSH-1:0] wr_sh;
    logic [NSH-1:0] upd;
    logic [3:0] meth [NSH];
    logic zero_eq_q;
    logic per_eq_q;
    logic tez_q;
    logic tep_q;
    logic sync_q;
    logic [15:0] red_cnt_q;
    logic [15:0] fed_cnt_q;
    logic [3:0] ps_q;
    logic [2:0] phase_q;
    logic [1:0] prev_q;
    logic [3:0] os_q [2];
    logic ost_q;
    logic cbc_q;
    logic out_a_q;
    logic out_b_q;
    logic trig0_q;
    logic trig1_q;

    pdc_dt_cfg_t dt;
    pdc_car_cfg_t car;
    pdc_trip0_t tr0;
    pdc_trip1_t tr1;
    pdc_trip1_t tr1_new;
    pdc_g1c_t g1c;
    logic wb_req;
    logic wr;
    logic [31:0] wnew;
    logic [31:0] rd;

    assign dt = pdc_dt_cfg_t'(dt_cfg_q);
    assign car = pdc_car_cfg_t'(car_q);
    assign tr0 = pdc_trip0_t'(trip0_q);
    assign tr1 = pdc_trip1_t'(trip1_q);
    assign g1c = pdc_g1c_t'(sh_q[4]);

    // Bus: every access is acked one cycle after it is seen; writes commit on that edge.
    assign wb_req = WB_CYC_I & WB_STB_I;
    assign wr = wb_req & WB_WE_I & !ack_q;

    always_comb begin
        wnew = wmerge(RST_WORD, WB_DAT_I, WB_SEL_I);
        case (WB_ADR_I)
            DT_CFG_OFS: wnew = wmerge(dt_cfg_q, WB_DAT_I, WB_SEL_I);
            CAR_OFS: wnew = wmerge(car_q, WB_DAT_I, WB_SEL_I);
            TRIP0_OFS: wnew = wmerge(trip0_q, WB_DAT_I, WB_SEL_I);
            TRIP1_OFS: wnew = wmerge(trip1_q, WB_DAT_I, WB_SEL_I);
            STC_OFS: wnew = wmerge({24'h0, stc_up_q}, WB_DAT_I, WB_SEL_I);
            default: wnew = wmerge(RST_WORD, WB_DAT_I, WB_SEL_I);
        endcase
    end
    assign tr1_new = pdc_trip1_t'(wnew);

    always_comb begin
        case (WB_ADR_I)
            DT_CFG_OFS: rd = dt_cfg_q;
            FED_OFS: rd = sh_q[0];
            RED_OFS: rd = sh_q[1];
            CAR_OFS: rd = car_q;
            TRIP0_OFS: rd = trip0_q;
            TRIP1_OFS: rd = trip1_q;
            TRIPS_OFS: rd = {30'h0, ost_q, cbc_q};
            STC_OFS: rd = {22'h0, pend_q[3], pend_q[2], stc_up_q};
            STA_OFS: rd = sh_q[2];
            STB_OFS: rd = sh_q[3];
            G1C_OFS: rd = sh_q[4];
            default: rd = RST_WORD;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
            rdat_q <= RST_WORD;
        end else begin
            ack_q <= wb_req & !ack_q;
            if (wb_req & !ack_q) begin
                rdat_q <= rd;
            end
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // Plain configuration registers.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dt_cfg_q <= RST_WORD;
            car_q <= RST_WORD;
            trip0_q <= RST_WORD;
            trip1_q <= RST_WORD;
            stc_up_q <= 8'h00;
        end else if (wr) begin
            if (WB_ADR_I == DT_CFG_OFS) dt_cfg_q <= {14'h0, wnew[17:0]};
            if (WB_ADR_I == CAR_OFS) car_q <= {18'h0, wnew[13:0]};
            if (WB_ADR_I == TRIP0_OFS) trip0_q <= {8'h0, wnew[23:0]};
            if (WB_ADR_I == TRIP1_OFS) trip1_q <= {27'h0, wnew[4:0]};
            if (WB_ADR_I == STC_OFS) stc_up_q <= wnew[7:0];
        end
    end

    // Timer events pulse for one cycle, one clock after the first cycle of each match; sync is only registered, not edge-detected.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            zero_eq_q <= 1'b0;
            per_eq_q <= 1'b0;
            tez_q <= 1'b0;
            tep_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            zero_eq_q <= TIMER_CNT == 16'h0000;
            per_eq_q <= TIMER_CNT == TIMER_PERIOD;
            tez_q <= (TIMER_CNT == 16'h0000) & !zero_eq_q;
            tep_q <= (TIMER_CNT == TIMER_PERIOD) & !per_eq_q;
            sync_q <= SYNC_IN;
        end
    end

    // Shadowed values: delays, stamps and generator 1 configuration.
    always_comb begin
        meth[0] = dt.fed_up;
        meth[1] = dt.red_up;
        meth[2] = stc_up_q[3:0];
        meth[3] = stc_up_q[7:4];
        meth[4] = g1c.cfg_up;
    end

    for (genvar i = 0; i < NSH; i++) begin : g_sh
        assign wr_sh[i] = wr & (WB_ADR_I == SH_OFS[i]);
        assign upd[i] = upd_now(meth[i], tez_q, tep_q, sync_q);
        always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
                sh_q[i] <= RST_WORD;
                act_q[i] <= RST_WORD;
                pend_q[i] <= 1'b0;
            end else begin
                if (wr_sh[i]) begin
                    sh_q[i] <= wmerge(sh_q[i], WB_DAT_I, WB_SEL_I) & SH_MASK[i];
                end
                if (upd[i]) begin
                    act_q[i] <= sh_q[i];
                end
                pend_q[i] <= wr_sh[i] | (pend_q[i] & !upd[i]);
            end
        end
    end

    // Dead time: rising delay holds off each rise, falling delay stretches each fall.
    logic dt_tick;
    logic red_src;
    logic fed_src;
    logic red_x;
    logic fed_x;
    logic a_pre;
    logic b_pre;
    logic [1:0] dt_o;

    assign dt_tick = dt.clk_sel ? TIMER_PRESCALED_CLOCK : 1'b1;
    assign red_src = dt.red_insel ? PWM_B_IN : PWM_A_IN;
    assign red_x = (red_src & (red_cnt_q >= act_q[1][15:0])) ^ dt.red_inv;
    assign fed_src = dt.dual_edge_b_path_mode ? red_x : (dt.fed_insel ? PWM_B_IN : PWM_A_IN);
    assign fed_x = (fed_src | (fed_cnt_q < act_q[0][15:0])) ^ dt.fed_inv;
    assign a_pre = (dt.a_bypass | dt.dual_edge_b_path_mode) ? PWM_A_IN : red_x;
    assign b_pre = dt.b_bypass ? PWM_B_IN : fed_x;
    assign dt_o[0] = dt.a_swap ? b_pre : a_pre;
    assign dt_o[1] = dt.b_swap ? a_pre : b_pre;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            red_cnt_q <= 16'h0000;
            fed_cnt_q <= 16'h0000;
        end else begin
            if (!red_src) begin
                red_cnt_q <= 16'h0000;
            end else if (dt_tick && red_cnt_q != CNT_MAX) begin
                red_cnt_q <= red_cnt_q + 16'h0001;
            end
            if (fed_src) begin
                fed_cnt_q <= 16'h0000;
            end else if (dt_tick && fed_cnt_q != CNT_MAX) begin
                fed_cnt_q <= fed_cnt_q + 16'h0001;
            end
        end
    end

    // Carrier: eight phases per carrier period, each phase prescale+1 clocks long.
    logic ctick;
    logic cend;
    logic carrier;
    logic [1:0] cin;
    logic [1:0] car_o;

    assign ctick = ps_q == car.prescale;
    assign cend = ctick & (phase_q == 3'h7);
    assign carrier = phase_q < car.duty;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ps_q <= 4'h0;
            phase_q <= 3'h0;
        end else begin
            ps_q <= ctick ? 4'h0 : ps_q + 4'h1;
            if (ctick) begin
                phase_q <= phase_q + 3'h1;
            end
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_car
        logic rise;
        logic first;
        assign cin[c] = dt_o[c] ^ car.in_inv;
        assign rise = cin[c] & !prev_q[c];
        assign first = (os_q[c] != 4'h0) | (rise & (car.first_pulse_width != 4'h0));
        assign car_o[c] = (car.en ? (cin[c] & (first | carrier)) : cin[c])
            ^ car.out_inv;
        always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
                prev_q[c] <= 1'b0;
                os_q[c] <= 4'h0;
            end else begin
                prev_q[c] <= cin[c];
                if (rise) begin
                    os_q[c] <= car.first_pulse_width;
                end else if (!cin[c]) begin
                    os_q[c] <= 4'h0;
                end else if (cend && os_q[c] != 4'h0) begin
                    os_q[c] <= os_q[c] - 4'h1;
                end
            end
        end
    end

    // Trip handling.
    logic wr_tr1;
    logic sw_ost_evt;
    logic sw_cbc_evt;
    logic clr_evt;
    logic ost_trig;
    logic cbc_trig;
    logic refresh;
    pdc_act_t act_a;
    pdc_act_t act_b;

    assign wr_tr1 = wr & (WB_ADR_I == TRIP1_OFS);
    assign sw_ost_evt = wr_tr1 & (tr1_new.force_ost != tr1.force_ost) & tr0.ost_en[3];
    assign sw_cbc_evt = wr_tr1 & (tr1_new.force_cbc != tr1.force_cbc) & tr0.cbc_en[3];
    assign clr_evt = wr_tr1 & (tr1_new.clr_ost != tr1.clr_ost);
    assign ost_trig = (|(FAULT_IN & tr0.ost_en[2:0])) | sw_ost_evt;
    assign cbc_trig = (|(FAULT_IN & tr0.cbc_en[2:0])) | sw_cbc_evt;
    assign refresh = (tez_q & tr1.refresh_sel[0]) | (tep_q & tr1.refresh_sel[1]);

    always_comb begin
        act_a = ACT_NONE;
        act_b = ACT_NONE;
        if (ost_q) begin
            act_a = TIMER_DIR_DOWN ? tr0.a_ost_d : tr0.a_ost_u;
            act_b = TIMER_DIR_DOWN ? tr0.b_ost_d : tr0.b_ost_u;
        end else if (cbc_q) begin
            act_a = TIMER_DIR_DOWN ? tr0.a_cbc_d : tr0.a_cbc_u;
            act_b = TIMER_DIR_DOWN ? tr0.b_cbc_d : tr0.b_cbc_u;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ost_q <= 1'b0;
            cbc_q <= 1'b0;
        end else begin
            ost_q <= ost_trig | (ost_q & !clr_evt);
            cbc_q <= cbc_trig | (cbc_q & !refresh);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            out_a_q <= act_apply(act_a, car_o[0]);
            out_b_q <= act_apply(act_b, car_o[1]);
        end
    end

    // Generator 1 triggers follow the shadow select at once.
    function automatic logic tsrc(input logic [2:0] s, input logic [2:0] f, input logic y);
        case (s)
            3'h0, 3'h1, 3'h2: tsrc = f[s[1:0]];
            TSEL_SYNC: tsrc = y;
            default: tsrc = 1'b0;
        endcase
    endfunction

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            trig0_q <= 1'b0;
            trig1_q <= 1'b0;
        end else begin
            trig0_q <= tsrc(g1c.t0_sel, FAULT_IN, sync_q);
            trig1_q <= tsrc(g1c.t1_sel, FAULT_IN, sync_q);
        end
    end

    assign OPERATOR0_OUTPUT_A = out_a_q;
    assign OPERATOR0_OUTPUT_B = out_b_q;
    assign GENERATOR_TRIGGER_ZERO = trig0_q;
    assign GENERATOR_TRIGGER_ONE = trig1_q;
    assign GEN1_STAMP_A = act_q[2][15:0];
    assign GEN1_STAMP_B = act_q[3][15:0];
    assign GEN1_CFG_ACTIVE = act_q[4][9:0];
    assign ONESHOT_ACTIVE_FLAG = ost_q;
    assign PER_CYCLE_ACTIVE_FLAG = cbc_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_bus_req;
        wb_req && !ack_q;
    endsequence
    sequence s_stamp_imm;
        wr_sh[2] && meth[2] == 4'h0;
    endsequence

    bus_ack_once_a: assert property (s_bus_req |=> ack_q ##1 !ack_q)
        else $error("bus ack not a single pulse");
    ost_start_a: assert property (ost_trig |=> ost_q)
        else $error("one-shot trip did not start");
    ost_persist_a: assert property (ost_q && !clr_evt |=> ost_q)
        else $error("one-shot trip ended without clear");
    ost_clear_a: assert property (ost_q && clr_evt && !ost_trig |=> !ost_q)
        else $error("one-shot clear ignored");
    sw_ost_gate_a: assert property (
        !ost_q && !tr0.ost_en[3] && !(|(FAULT_IN & tr0.ost_en[2:0])) |=> !ost_q)
        else $error("one-shot trip without enabled source");
    cbc_release_a: assert property (cbc_q && refresh && !cbc_trig |=> !cbc_q)
        else $error("per-cycle trip not released");
    stamp_pend_a: assert property (s_stamp_imm |=> pend_q[2] ##1
        (!pend_q[2] && act_q[2] == $past(sh_q[2])))
        else $error("stamp A pending or load wrong");
    red_block_a: assert property (dt.red_up[UPD_OFF] |=> act_q[1] == $past(act_q[1]))
        else $error("blocked rising delay updated");
    trig_sync_a: assert property (g1c.t0_sel == TSEL_SYNC |=> trig0_q == $past(sync_q))
        else $error("trigger zero not following sync");
    tez_pulse_a: assert property (tez_q |=> !tez_q)
        else $error("timer zero event longer than one cycle");

endmodule

// ==== sim/pdc_stage_model.sv ====
// Power stage stand-in that counts the cycles in which output A is driven high.
// Assumes the core's outputs are settled at each rising clock edge.
module pdc_stage_model
    import pdc_pkg::*;
(
    // Clock and count control.
    input wire logic clk,
    input wire logic clr,
    // Gate drive from the core.
    input wire logic drive_a,
    input wire logic drive_b,
    // High-time tally.
    output logic [15:0] hi_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge clk) begin
        if (clr) begin
            hi_cnt <= 16'h0000;
        end else begin
            hi_cnt <= hi_cnt + {15'h0000, drive_a};
        end
    end
endmodule

// ==== sim/pdc_core_bench.sv ====
// Self-checking bench of the PWM dead-time, carrier and trip core.
// Assumes the core acks a bus request one cycle after taking it.
module pdc_core_bench
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] v;
        logic [31:0] m;
    } pdc_exp_t;

    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b1;
    logic dn = 1'b0, tick = 1'b0, sync = 1'b0, pa = 1'b0, pb = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [2:0] flt = 3'h0;
    logic [1:0] smp = 2'h0;
    logic [31:0] wdat = 32'h0, rdat, pv, obs;
    logic [15:0] cnt = 16'h0005, per = 16'h0064, stamp_a, stamp_b, hi_cnt;
    logic [9:0] cfg_act;
    logic ack, oa, ob, tr0, tr1, ostf, cbcf;
    int num_errors = 0, tests_run = 0;
    pdc_exp_t q[$];
    pdc_exp_t e;

    always #4 clk = ~clk;
    assign pv = {cfg_act, stamp_a, tr1, tr0, ostf, cbcf, ob, oa};

    pdc_core pdc_core_i (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TIMER_CNT(cnt), .TIMER_PERIOD(per), .TIMER_DIR_DOWN(dn),
        .TIMER_PRESCALED_CLOCK(tick), .SYNC_IN(sync), .PWM_A_IN(pa), .PWM_B_IN(pb),
        .FAULT_IN(flt), .OPERATOR0_OUTPUT_A(oa), .OPERATOR0_OUTPUT_B(ob),
        .GENERATOR_TRIGGER_ZERO(tr0), .GENERATOR_TRIGGER_ONE(tr1), .GEN1_STAMP_A(stamp_a),
        .GEN1_STAMP_B(stamp_b), .GEN1_CFG_ACTIVE(cfg_act), .ONESHOT_ACTIVE_FLAG(ostf),
        .PER_CYCLE_ACTIVE_FLAG(cbcf));

    pdc_stage_model pdc_stage_model_i (.clk(clk), .clr(clr), .drive_a(oa), .drive_b(ob),
        .hi_cnt(hi_cnt));

    // Read data, a probe word of the outputs, the stage tally or stamp B is held against the oldest note.
    always @(posedge clk) begin
        if ((ack && !we) || smp != 2'h0) begin
            obs = (smp == 2'h1) ? pv : (smp == 2'h2) ? {16'h0000, hi_cnt} :
                (smp == 2'h3) ? {16'h0000, stamp_b} : rdat;
            e = (q.size() > 0) ? q.pop_front() : pdc_exp_t'{~obs, 32'hffff_ffff};
            tests_run++;
            if ((obs & e.m) !== (e.v & e.m)) begin
                num_errors++;
                $display("BAD t=%0t got %h exp %h", $time, obs & e.m, e.v & e.m);
            end
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            num_errors++;
            end_of_test();
        end
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(pdc_exp_t'{x, 32'hffff_ffff});
        wb(1'b0, a, 32'h0);
    endtask

    task automatic chk(input logic [1:0] s, input logic [31:0] m, input logic [31:0] x);
        q.push_back(pdc_exp_t'{x, m});
        smp <= s;
        @(posedge clk);
        smp <= 2'h0;
    endtask

    // Pulses one timer or sync event: bit 0 zero, bit 1 period, bit 2 sync.
    task automatic ev(input int m);
        if (m[0]) cnt <= 16'h0000;
        if (m[1]) cnt <= per;
        if (m[2]) sync <= 1'b1;
        @(posedge clk);
        cnt <= 16'h0005;
        sync <= 1'b0;
        cyc_n(3);
    endtask

    // Drives one n-cycle pulse on input A and checks the stage's high-time tally.
    task automatic pulse(input int n, input logic [31:0] x);
        clr <= 1'b0;
        pa <= 1'b1;
        cyc_n(n);
        pa <= 1'b0;
        cyc_n(20);
        clr <= 1'b1;
        chk(2'h2, 32'hffff, x);
    endtask

    initial begin
        int i, k;
        logic [31:0] d, sa, sb;
        void'($urandom(28));
        cyc_n(10);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 12; i++) begin
            rd(8'h58 + 8'(4 * i), 32'h0);
        end
        for (k = 0; k < 4; k++) begin
            d = $urandom;
            wb(1'b1, SH_OFS[k], d);
            rd(SH_OFS[k], d & SH_MASK[k]);
            if (k == 2) sa = d & 32'h0000_ffff;
            if (k == 3) sb = d & 32'h0000_ffff;
        end
        wb(1'b1, FED_OFS, 32'h0);
        wb(1'b1, RED_OFS, 32'h0);
        wb(1'b1, TRIPS_OFS, 32'hffff_ffff);
        wb(1'b1, 8'h84, 32'hffff_ffff);
        rd(TRIPS_OFS, 32'h0);
        rd(8'h84, 32'h0);
        chk(2'h3, 32'hffff, sb);
        // Output B bypasses the dead-time stage so that it follows input B.
        wb(1'b1, DT_CFG_OFS, 32'h0001_0000);
        for (i = 0; i < 4; i++) begin
            d = 32'h0000_1230 + 32'(i);
            wb(1'b1, STC_OFS, 32'(1 << i));
            wb(1'b1, STA_OFS, d);
            rd(STC_OFS, 32'(1 << i) | 32'h100);
            ev((i == 3) ? 1 : (1 << i));
            if (i != 3) sa = d;
            chk(2'h1, 32'h003f_ffc0, {10'h0, sa[15:0], 6'h0});
            rd(STC_OFS, 32'(1 << i) | ((i == 3) ? 32'h100 : 32'h0));
        end
        pa <= 1'b1;
        wb(1'b1, TRIP0_OFS, 32'h0010_9060);
        wb(1'b1, TRIP1_OFS, 32'h10);
        flt <= 3'h2;
        cyc_n(3);
        chk(2'h1, 32'hf, 32'h1);
        flt <= 3'h1;
        cyc_n(3);
        flt <= 3'h0;
        cyc_n(3);
        chk(2'h1, 32'hf, 32'ha);
        rd(TRIPS_OFS, 32'h2);
        wb(1'b1, TRIP1_OFS, 32'h11);
        cyc_n(2);
        chk(2'h1, 32'hf, 32'h1);
        dn <= 1'b1;
        pa <= 1'b0;
        pb <= 1'b1;
        wb(1'b1, TRIP0_OFS, 32'h0090_9060);
        wb(1'b1, TRIP1_OFS, 32'h01);
        cyc_n(2);
        chk(2'h1, 32'hf, 32'h9);
        wb(1'b1, TRIP1_OFS, 32'h00);
        dn <= 1'b0;
        pb <= 1'b0;
        wb(1'b1, TRIP0_OFS, 32'h0004_0808);
        wb(1'b1, TRIP1_OFS, 32'h2);
        flt <= 3'h1;
        cyc_n(3);
        chk(2'h1, 32'hf, 32'h0);
        flt <= 3'h4;
        cyc_n(3);
        flt <= 3'h0;
        ev(2);
        chk(2'h1, 32'hf, 32'h7);
        rd(TRIPS_OFS, 32'h1);
        ev(1);
        chk(2'h1, 32'hf, 32'h0);
        wb(1'b1, TRIP0_OFS, 32'h000c_0808);
        wb(1'b1, TRIP1_OFS, 32'ha);
        cyc_n(2);
        chk(2'h1, 32'hf, 32'h7);
        ev(1);
        chk(2'h1, 32'hf, 32'h0);
        wb(1'b1, TRIP0_OFS, 32'h0);
        for (i = 0; i < 5; i++) begin
            d = 32'h200 | 32'(i << 4);
            wb(1'b1, G1C_OFS, d);
            flt <= (i < 3) ? 3'(1 << i) : (i == 4) ? 3'h7 : 3'h0;
            sync <= (i >= 3);
            // A sync needs one clock to be taken before it can reach a trigger.
            repeat ((i == 3) ? 2 : 1) @(posedge clk);
            chk(2'h1, 32'hffc0_0030, {d[9:0], 16'h0, 1'b0, i < 4, 4'h0});
            flt <= 3'h0;
            sync <= 1'b0;
        end
        wb(1'b1, G1C_OFS, 32'h0);
        // Dual-edge mode with B swapped onto A: high time is n - rising + falling delay.
        wb(1'b1, DT_CFG_OFS, 32'h0000_0310);
        wb(1'b1, FED_OFS, 32'h3);
        wb(1'b1, RED_OFS, 32'h5);
        pulse(10, 32'hd);
        ev(1);
        pulse(10, 32'h8);
        wb(1'b1, DT_CFG_OFS, 32'h0002_0380);
        wb(1'b1, RED_OFS, 32'h1);
        ev(1);
        pulse(10, 32'h0);
        tick <= 1'b1;
        pulse(10, 32'h8);
        wb(1'b1, DT_CFG_OFS, 32'h0001_0000);
        wb(1'b1, RED_OFS, 32'h0);
        wb(1'b1, FED_OFS, 32'h0);
        pa <= 1'b1;
        wb(1'b1, CAR_OFS, 32'h2000);
        cyc_n(2);
        chk(2'h1, 32'h3, 32'h2);
        wb(1'b1, CAR_OFS, 32'h3000);
        cyc_n(2);
        chk(2'h1, 32'h3, 32'h1);
        // Windows span whole carrier periods, so the high count is exact.
        for (i = 0; i < 3; i++) begin
            k = i + 1;
            d = 32'(i * 2 + 3);
            wb(1'b1, CAR_OFS, 32'h201 | 32'(k << 1) | (d << 5));
            cyc_n(200);
            clr <= 1'b0;
            cyc_n(64 * (k + 1));
            clr <= 1'b1;
            chk(2'h2, 32'hffff, 32'(8 * d * (k + 1)));
        end
        end_of_test();
    end
endmodule
